/* File: core/fspb_pkg.sv */
// Package for the framed serial port buffer: constants, modes and carriers.
// Assumes a single 200 MHz system clock and byte-wide serial codec outside.
`default_nettype none
package fspb_pkg;
  localparam int          FSPB_AW          = 11;       // Word address width of one buffer
  localparam int          FSPB_WORDS       = 2048;     // Words per buffer
  localparam logic [15:0] FSPB_MAX_TX      = 16'h0800; // Largest send byte count
  localparam logic [7:0]  FSPB_STX         = 8'h02;    // Start code
  localparam logic [7:0]  FSPB_CR          = 8'h0D;    // End code CR
  localparam logic [7:0]  FSPB_LF          = 8'h0A;    // Second end byte for CR+LF
  localparam logic [7:0]  FSPB_ETX         = 8'h03;    // End code ETX
  localparam logic [15:0] FSPB_COUNT_RST   = 16'h0000; // Count word after reset
  localparam logic [FSPB_AW-1:0] FSPB_PTR_RST = 11'h001; // First data word

  typedef enum logic [1:0] {
    FSPB_TERM_CR,
    FSPB_TERM_CRLF,
    FSPB_TERM_NONE,
    FSPB_TERM_ETX
  } fspb_term_type;

  // Port configuration, one per instance
  typedef struct packed {
    logic          hdr_en;     // Start code on send and receive
    fspb_term_type term;       // End code choice
    logic [10:0]   rx_words;   // Receive buffer capacity in words
  } fspb_cfg_type;

  // Port flags
  typedef struct packed {
    logic rx_done;
    logic tx_done;
    logic error;
  } fspb_flags_type;
endpackage : fspb_pkg
`default_nettype wire

/* File: core/fspb_port.sv */
// One general-purpose framed serial port: send table, receive buffer, flags.
// Assumes an external byte codec (tx valid/ready, rx strobe) on this clock.
// Contract
// - End code appended automatically to every send with a non-negative count, unless the no-end choice is set
// - Start code sent first when enabled
// - No transmission while synchronised clear-to-send is low
// - First receive word holds count, from zero
// - Payload from word two, low then high
// - End code sets done, further bytes ignored
// - Command clears count and write pointer
// - Re-arm leaves buffer contents untouched
// - Mid-message start code restarts the buffer
// - Command clears error and reception done flags
// - Bytes still accepted after error flag
// - Reception done low after entering run
// - Send payload word order, low byte first
// - Send clears count word, raises done
// - Negative count suppresses end code
`default_nettype none
module fspb_port
  import fspb_pkg::*;
(
  // Clock and reset
  input  wire logic           i_clk_sys,
  input  wire logic           i_rst_n,
  // Configuration and run
  input  wire fspb_cfg_type   i_cfg,
  input  wire logic           i_run,
  // Send / restart command with signed byte count
  input  wire logic           i_cmd,
  input  wire logic [15:0]    i_cmd_count,
  // Send table write port (word 0 is never sent; data from word 1)
  input  wire logic           i_tx_we,
  input  wire logic [10:0]    i_tx_addr,
  input  wire logic [15:0]    i_tx_wdata,
  // Receive buffer read port
  input  wire logic [10:0]    i_rx_addr,
  output logic [15:0]         o_rx_rdata,
  // Serial byte codec
  output logic                o_tx_valid,
  output logic [7:0]          o_tx_byte,
  input  wire logic           i_tx_ready,
  input  wire logic           i_cts,
  input  wire logic           i_rx_stb,
  input  wire logic [7:0]     i_rx_byte,
  input  wire logic           i_rx_err,
  // Flags and send count word
  output fspb_flags_type      o_flags,
  output logic [15:0]         o_tx_count
);
  typedef enum logic [2:0] {
    FSPB_T_IDLE, FSPB_T_HDR, FSPB_T_LOAD, FSPB_T_DATA, FSPB_T_END1, FSPB_T_END2
  } fspb_tst_type;

  // Memories declared here; each instance owns its own
  logic [15:0] tx_mem [FSPB_WORDS];
  logic [15:0] rx_mem [FSPB_WORDS];

  logic         cts;
  fspb_tst_type tst_reg,  tst_next;
  logic [15:0]  left_reg, left_next;
  logic [10:0]  tptr_reg, tptr_next;
  logic         hi_reg,   hi_next;
  logic         noend_reg, noend_next;
  logic [15:0]  word_reg, word_next;
  logic [15:0]  cnt_reg,  cnt_next;
  logic [15:0]  rcnt_reg, rcnt_next;
  logic [10:0]  rptr_reg, rptr_next;
  logic         rhi_reg,  rhi_next;
  logic         rdone_reg, rdone_next;
  logic         tdone_reg, tdone_next;
  logic         err_reg,  err_next;
  logic         run_reg;
  logic         rx_we;
  logic [15:0]  rx_wdata;
  logic [15:0]  mag;
  logic [7:0]   end1;
  logic         term_hit;
  logic         sent;
  logic         err_set;

  // Transmit walk, one state per kind of byte on the line:
  // Idle waits for a command while the done flag stands high.
  // A command presets the count word with the clipped magnitude.
  // The same command re-arms reception and clears the error and reception done flags.
  // A command with nothing to send leaves the done flag high.
  // Header state offers the start code when the option is on.
  // Load state fetches the next table word from the send table.
  // Data state offers the low byte, then the high byte of that word.
  // Odd counts stop after a low byte and never touch the high byte.
  // End states offer one or two end codes unless suppressed.
  // A negative count or the no-end choice suppresses the end code.
  // Leaving the last state clears the count word and raises done.
  // Every offer waits for clear-to-send and for the codec's ready.
  // An offered byte never changes until the codec has taken it.
  // Clear-to-send is an outside level, so it is synchronised first.
  // Its change therefore reaches the offer three to four cycles late.
  // A byte already offered may still go once clear-to-send drops.
  //
  // Receive walk, one decision per strobe from the codec:
  // Strobes are ignored while the reception done flag stands high.
  // A start code, with the option on, restarts count and pointer.
  // The end code raises the done flag and is itself not stored.
  // With CR plus LF framing the CR is dropped and LF ends the frame.
  // Any other byte lands in the low half, then the high half.
  // The other half of the word is read back and kept as it was.
  // The count word grows by one for every stored byte.
  // A byte past the configured capacity sets the error flag instead.
  // A codec error also sets the error flag, and storing goes on.
  // An error that arrives with a command outlives the clear.
  // The command beats an end code that arrives in the same cycle.
  // Entering run lowers the done flag so reception can start.
  // Buffer words are never cleared; only count and pointer move.
  // The read port answers one cycle after the address is given.
  // Address zero of the read port returns the live count word.

  fspb_sync u_cts (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async   (i_cts),
    .o_level   (cts)
  );

  // Derived send quantities
  always_comb begin
    mag  = i_cmd_count[15] ? 16'(-i_cmd_count) : i_cmd_count;
    if (mag > FSPB_MAX_TX) mag = FSPB_MAX_TX;
    case (i_cfg.term)
      FSPB_TERM_ETX: end1 = FSPB_ETX;
      default:       end1 = FSPB_CR;
    endcase
    term_hit = (i_cfg.term == FSPB_TERM_ETX && i_rx_byte == FSPB_ETX) ||
               (i_cfg.term == FSPB_TERM_CR && i_rx_byte == FSPB_CR) ||
               (i_cfg.term == FSPB_TERM_CRLF && i_rx_byte == FSPB_LF);
    sent = o_tx_valid && i_tx_ready;
  end

  // Transmit byte stream
  always_comb begin
    o_tx_valid = 1'b0;
    o_tx_byte  = 8'h00;
    case (tst_reg)
      FSPB_T_HDR:  begin o_tx_valid = cts; o_tx_byte = FSPB_STX; end
      FSPB_T_DATA: begin
        o_tx_valid = cts;
        o_tx_byte  = hi_reg ? word_reg[15:8] : word_reg[7:0];
      end
      FSPB_T_END1: begin o_tx_valid = cts; o_tx_byte = end1; end
      FSPB_T_END2: begin o_tx_valid = cts; o_tx_byte = FSPB_LF; end
      default:     ;
    endcase
  end

  // Transmit sequencer; the controller must not re-issue before done
  always_comb begin
    tst_next   = tst_reg;
    left_next  = left_reg;
    tptr_next  = tptr_reg;
    hi_next    = hi_reg;
    noend_next = noend_reg;
    word_next  = word_reg;
    cnt_next   = cnt_reg;
    tdone_next = tdone_reg;
    case (tst_reg)
      FSPB_T_IDLE: if (i_cmd) begin
        left_next  = mag;
        cnt_next   = mag;
        noend_next = i_cmd_count[15] || i_cfg.term == FSPB_TERM_NONE;
        tptr_next  = FSPB_PTR_RST;
        hi_next    = 1'b0;
        if (mag != 16'h0000 || !noend_next || i_cfg.hdr_en) begin
          tdone_next = 1'b0;
          tst_next   = i_cfg.hdr_en ? FSPB_T_HDR : FSPB_T_LOAD;
        end
      end
      FSPB_T_HDR:  if (sent) tst_next = FSPB_T_LOAD;
      FSPB_T_LOAD: begin
        word_next = tx_mem[tptr_reg];
        if (left_reg == 16'h0000)
          tst_next = noend_reg ? FSPB_T_IDLE : FSPB_T_END1;
        else
          tst_next = FSPB_T_DATA;
        if (left_reg == 16'h0000 && noend_reg) begin
          cnt_next   = 16'h0000;
          tdone_next = 1'b1;
        end
      end
      FSPB_T_DATA: if (sent) begin
        left_next = left_reg - 16'h0001;
        hi_next   = !hi_reg;
        if (hi_reg) tptr_next = tptr_reg + 11'h001;
        tst_next  = (hi_reg || left_reg == 16'h0001) ? FSPB_T_LOAD : FSPB_T_DATA;
      end
      FSPB_T_END1: if (sent) begin
        if (i_cfg.term == FSPB_TERM_CRLF) tst_next = FSPB_T_END2;
        else begin
          tst_next   = FSPB_T_IDLE;
          cnt_next   = 16'h0000;
          tdone_next = 1'b1;
        end
      end
      FSPB_T_END2: if (sent) begin
        tst_next   = FSPB_T_IDLE;
        cnt_next   = 16'h0000;
        tdone_next = 1'b1;
      end
      default: tst_next = FSPB_T_IDLE;
    endcase
  end

  // Receive framing, count and flags
  always_comb begin
    rcnt_next  = rcnt_reg;
    rptr_next  = rptr_reg;
    rhi_next   = rhi_reg;
    rdone_next = rdone_reg;
    err_next   = err_reg;
    rx_we      = 1'b0;
    rx_wdata   = 16'h0000;
    err_set    = 1'b0;
    if (i_run && !run_reg) rdone_next = 1'b0;
    if (i_rx_stb && !rdone_reg) begin
      if (i_rx_err) err_set = 1'b1;
      if (i_cfg.hdr_en && i_rx_byte == FSPB_STX) begin
        rcnt_next = FSPB_COUNT_RST;
        rptr_next = FSPB_PTR_RST;
        rhi_next  = 1'b0;
      end else if (term_hit) begin
        rdone_next = 1'b1;
      end else if (!(i_cfg.term == FSPB_TERM_CRLF && i_rx_byte == FSPB_CR)) begin
        if (rptr_reg < i_cfg.rx_words) begin
          rx_we     = 1'b1;
          rx_wdata  = rhi_reg ? {i_rx_byte, rx_mem[rptr_reg][7:0]}
                              : {rx_mem[rptr_reg][15:8], i_rx_byte};
          rcnt_next = rcnt_reg + 16'h0001;
          rhi_next  = !rhi_reg;
          if (rhi_reg) rptr_next = rptr_reg + 11'h001;
        end else err_set = 1'b1;
      end
    end
    if (err_set) err_next = 1'b1;
    // Command wins over a same-cycle end code, as the port documents it
    if (i_cmd && tst_reg == FSPB_T_IDLE) begin
      rcnt_next  = FSPB_COUNT_RST;
      rptr_next  = FSPB_PTR_RST;
      rhi_next   = 1'b0;
      rdone_next = 1'b0;
      err_next   = err_set;                                               // Set wins
    end
  end

  // Buffers: count word read back at address 0, not stored
  always_ff @(posedge i_clk_sys) begin
    if (i_tx_we) tx_mem[i_tx_addr] <= i_tx_wdata;
    if (rx_we) rx_mem[rptr_reg] <= rx_wdata;
    o_rx_rdata <= (i_rx_addr == 11'h000) ? rcnt_reg : rx_mem[i_rx_addr];
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tst_reg   <= FSPB_T_IDLE;
      left_reg  <= 16'h0000;
      tptr_reg  <= FSPB_PTR_RST;
      hi_reg    <= 1'b0;
      noend_reg <= 1'b0;
      word_reg  <= 16'h0000;
      cnt_reg   <= FSPB_COUNT_RST;
      rcnt_reg  <= FSPB_COUNT_RST;
      rptr_reg  <= FSPB_PTR_RST;
      rhi_reg   <= 1'b0;
      rdone_reg <= 1'b0;
      tdone_reg <= 1'b1;
      err_reg   <= 1'b0;
      run_reg   <= 1'b0;
    end else begin
      tst_reg   <= tst_next;
      left_reg  <= left_next;
      tptr_reg  <= tptr_next;
      hi_reg    <= hi_next;
      noend_reg <= noend_next;
      word_reg  <= word_next;
      cnt_reg   <= cnt_next;
      rcnt_reg  <= rcnt_next;
      rptr_reg  <= rptr_next;
      rhi_reg   <= rhi_next;
      rdone_reg <= rdone_next;
      tdone_reg <= tdone_next;
      err_reg   <= err_next;
      run_reg   <= i_run;
    end
  end

  // Flags come straight from registers; controller samples once
  assign o_flags    = '{rx_done: rdone_reg, tx_done: tdone_reg, error: err_reg};
  assign o_tx_count = cnt_reg;
endmodule : fspb_port
`default_nettype wire

/* File: core/fspb_sync.sv */
// Three-stage synchroniser for a level from outside the clock domain.
// Output changes only once stages two and three agree.
`default_nettype none
module fspb_sync
  import fspb_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  // Level in and filtered level out
  input  wire logic i_async,
  output logic      o_level
);
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic       lvl_reg;
  logic       lvl_next;

  // Shift and agree
  always_comb begin
    sh_next  = {sh_reg[1:0], i_async};
    lvl_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : lvl_reg;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_reg  <= 3'h0;
      lvl_reg <= 1'b0;
    end else begin
      sh_reg  <= sh_next;
      lvl_reg <= lvl_next;
    end
  end

  assign o_level = lvl_reg;
endmodule : fspb_sync
`default_nettype wire

/* File: sim/fspb_dev_model.sv */
// Far-side serial device: takes sent bytes with stalls, sends bytes in.
// Assumes the port byte codec on i_clk_sys; drives at the falling edge.
`default_nettype none
module fspb_dev_model (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  // Codec towards the port
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_tx_ready,
  output logic            o_rx_stb,
  output logic [7:0]      o_rx_byte,
  output logic            o_rx_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] seen_q[$];
  logic       slow = 1'b0;
  logic [1:0] cyc = 2'b00;
  initial {o_tx_ready, o_rx_stb, o_rx_err, o_rx_byte} = 11'h0A5;
  // Record every byte taken off the line
  always @(posedge i_clk_sys) if (i_rst_n && i_tx_valid && o_tx_ready) seen_q.push_back(i_tx_byte);
  // Ready, stalling three cycles in four when slow
  always @(negedge i_clk_sys) begin
    cyc <= cyc + 2'b01;
    o_tx_ready <= !slow || cyc == 2'b11;
  end
  // One received byte; the data line is scrambled once released
  task automatic put(input logic [7:0] b, input logic err);
    @(negedge i_clk_sys);
    {o_rx_stb, o_rx_byte, o_rx_err} = {1'b1, b, err};
    @(negedge i_clk_sys);
    {o_rx_stb, o_rx_byte, o_rx_err} = {1'b0, ~b, 1'b0};
  endtask : put
endmodule : fspb_dev_model
`default_nettype wire

/* File: sim/fspb_port_chk.sv */
// Checker for one framed serial port: flags, send handshake, clear-to-send.
// Sees only the port pins; bound to every fspb_port instance.
`default_nettype none
module fspb_port_chk
  import fspb_pkg::*;
(
  // Clock and reset
  input wire logic           i_clk_sys,
  input wire logic           i_rst_n,
  // Inputs watched
  input wire logic           i_run,
  input wire logic           i_cmd,
  input wire logic [15:0]    i_cmd_count,
  input wire logic           i_tx_ready,
  input wire logic           i_cts,
  input wire logic           i_rx_stb,
  // Outputs watched
  input wire logic           o_tx_valid,
  input wire logic [7:0]     o_tx_byte,
  input wire fspb_flags_type o_flags,
  input wire logic [15:0]    o_tx_count
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Send side
  property p_cts; (!i_cts)[*6] |-> !o_tx_valid; endproperty
  a_cts: assert property (p_cts) else $error("byte offered with cts low");
  property p_hold; o_tx_valid && !i_tx_ready ##1 o_tx_valid |-> $stable(o_tx_byte); endproperty
  a_hold: assert property (p_hold) else $error("byte changed while waiting");
  property p_fall; i_cmd && o_flags.tx_done && i_cmd_count != 16'h0000 |=> !o_flags.tx_done;
  endproperty
  a_fall: assert property (p_fall) else $error("send done not lowered");
  property p_cnt; $rose(o_flags.tx_done) |-> o_tx_count == 16'h0000; endproperty
  a_cnt: assert property (p_cnt) else $error("count word not cleared");
  property p_idle; o_flags.tx_done |-> !o_tx_valid; endproperty
  a_idle: assert property (p_idle) else $error("byte offered while idle");
  // Flags
  property p_clr; i_cmd && o_flags.tx_done && !i_rx_stb |=> !o_flags.error && !o_flags.rx_done;
  endproperty
  a_clr: assert property (p_clr) else $error("command left a flag set");
  property p_keep; o_flags.rx_done && !i_cmd && i_run && $past(i_run) && $past(i_run, 2)
    |=> o_flags.rx_done; endproperty
  a_keep: assert property (p_keep) else $error("receive done dropped");
  property p_run; $rose(i_run) |-> ##[1:2] !o_flags.rx_done; endproperty
  a_run: assert property (p_run) else $error("receive done after run");
  property p_rxr; $rose(o_flags.rx_done) |-> $past(i_rx_stb) || $past(i_rx_stb, 2); endproperty
  a_rxr: assert property (p_rxr) else $error("receive done without byte");
  property p_err; $rose(o_flags.error) |-> $past(i_rx_stb) || $past(i_rx_stb, 2); endproperty
  a_err: assert property (p_err) else $error("error without byte");
  // Main scenarios
  c_rx: cover property ($rose(o_flags.rx_done));
  c_tx: cover property (o_tx_valid && i_tx_ready);
  c_err: cover property ($rose(o_flags.error));
endmodule : fspb_port_chk
bind fspb_port fspb_port_chk chk_u (.i_clk_sys, .i_rst_n, .i_run, .i_cmd, .i_cmd_count,
  .i_tx_ready, .i_cts, .i_rx_stb, .o_tx_valid, .o_tx_byte, .o_flags, .o_tx_count);
`default_nettype wire

/* File: sim/test_framed_serial_port_buffer.sv */
// Bench for one framed serial port: random sends, receive framing, flags.
// Assumes the far-side model dev_u and the bound checker.
`default_nettype none
`define CHK(s, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", s, e, g); end end
module test_framed_serial_port_buffer
  import fspb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] fspb_bq_type[$];
  logic           i_clk_sys, i_rst_n, i_run, i_cmd, i_tx_we, i_cts;
  logic           o_tx_valid, i_tx_ready, i_rx_stb, i_rx_err;
  logic [10:0]    i_tx_addr, i_rx_addr;
  logic [15:0]    i_cmd_count, i_tx_wdata, o_rx_rdata, o_tx_count;
  logic [15:0]    lfsr = 16'h0001;
  logic [7:0]     o_tx_byte, i_rx_byte, b0, b1;
  fspb_cfg_type   i_cfg;
  fspb_flags_type o_flags;
  fspb_flags_type fl;
  int             num_errors = 0;
  int             checks_done = 0;
  fspb_port dut_u (.i_clk_sys, .i_rst_n, .i_cfg, .i_run, .i_cmd, .i_cmd_count, .i_tx_we,
    .i_tx_addr, .i_tx_wdata, .i_rx_addr, .o_rx_rdata, .o_tx_valid, .o_tx_byte, .i_tx_ready,
    .i_cts, .i_rx_stb, .i_rx_byte, .i_rx_err, .o_flags, .o_tx_count);
  fspb_dev_model dev_u (.i_clk_sys, .i_rst_n, .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte),
    .o_tx_ready(i_tx_ready), .o_rx_stb(i_rx_stb), .o_rx_byte(i_rx_byte), .o_rx_err(i_rx_err));
  // 200 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next_rand
  // Payload byte kept clear of every framing code
  function automatic logic [7:0] pb();
    lfsr = next_rand(lfsr);
    return lfsr[7:0] | 8'h40;
  endfunction : pb
  // Bytes expected on the line for one send
  function automatic fspb_bq_type exp_frame(fspb_bq_type p, logic h, fspb_term_type t, logic n);
    fspb_bq_type q;
    q = p;
    if (h) q.push_front(FSPB_STX);
    if (!n && t != FSPB_TERM_NONE) q.push_back(t == FSPB_TERM_ETX ? FSPB_ETX : FSPB_CR);
    if (!n && t == FSPB_TERM_CRLF) q.push_back(FSPB_LF);
    return q;
  endfunction : exp_frame
  // Fill the table, command, wait for done, compare the line
  task automatic do_send(int n, logic neg, logic hdr, fspb_term_type t, int hold);
    fspb_bq_type p, ex;
    int w;
    i_cfg.hdr_en = hdr;
    i_cfg.term = t;
    dev_u.seen_q.delete();
    for (w = 1; w <= (n + 1) / 2; w++) begin
      @(negedge i_clk_sys);
      lfsr = next_rand(lfsr);
      {i_tx_we, i_tx_addr, i_tx_wdata} = {1'b1, w[10:0], lfsr};
      p.push_back(lfsr[7:0]);
      p.push_back(lfsr[15:8]);
    end
    if (n % 2) void'(p.pop_back());
    @(negedge i_clk_sys);
    {i_tx_we, i_cmd} = 2'b01;
    i_cmd_count = neg ? 16'(-n) : 16'(n);
    @(negedge i_clk_sys);
    i_cmd = 1'b0;
    `CHK("count preset", 16'(n), o_tx_count)
    if (hold > 0) begin
      repeat (hold) @(negedge i_clk_sys);
      `CHK("sent with cts low", 0, dev_u.seen_q.size())
      i_cts = 1'b1;
    end
    for (w = 0; w < 20000 && o_flags.tx_done !== 1'b1; w++) @(negedge i_clk_sys);
    `CHK("tx done", 1'b1, o_flags.tx_done)
    ex = exp_frame(p, hdr, t, neg);
    `CHK("tx length", ex.size(), dev_u.seen_q.size())
    foreach (ex[i]) `CHK("tx byte", ex[i], dev_u.seen_q[i])
    `CHK("count word", 16'h0000, o_tx_count)
  endtask : do_send
  // Zero-byte command re-arms reception, then framing is chosen
  task automatic restart(logic hdr, fspb_term_type t);
    do_send(0, 1'b0, 1'b0, FSPB_TERM_NONE, 0);
    i_cfg.hdr_en = hdr;
    i_cfg.term = t;
  endtask : restart
  task automatic send_rx(fspb_bq_type q, int err_at);
    foreach (q[i]) dev_u.put(q[i], i == err_at);
  endtask : send_rx
  // Read one receive word under a mask
  task automatic rx_word(logic [10:0] a, logic [15:0] m, logic [15:0] e, string s);
    @(negedge i_clk_sys);
    i_rx_addr = a;
    @(negedge i_clk_sys);
    `CHK(s, e, o_rx_rdata & m)
  endtask : rx_word
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge i_clk_sys);
    num_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {i_rst_n, i_run, i_cmd, i_tx_we, i_cts} = 5'b00001;
    {i_cmd_count, i_tx_addr, i_tx_wdata, i_rx_addr} = '0;
    i_cfg = '{1'b0, FSPB_TERM_CR, 11'h7FF};
    repeat (12) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    repeat (6) @(negedge i_clk_sys);
    i_run = 1'b1;
    `CHK("tx done at reset", 1'b1, o_flags.tx_done)
    for (int t = 0; t < 8; t++) begin
      dev_u.slow = lfsr[6];
      do_send(lfsr[3:0] + 1, t == 3, t[0], fspb_term_type'(t[2:1]), 0);
    end
    dev_u.slow = 1'b1;
    do_send(2048, 1'b0, 1'b1, FSPB_TERM_ETX, 0);
    i_cts = 1'b0;
    repeat (6) @(negedge i_clk_sys);
    do_send(3, 1'b0, 1'b0, FSPB_TERM_CR, 30);
    $display("test send done");
    restart(1'b0, FSPB_TERM_CR);
    b0 = pb();
    b1 = pb();
    send_rx('{b0, b1, 8'h5A, FSPB_CR}, -1);
    fl = o_flags; // One sampled copy of the flags
    `CHK("rx done", 1'b1, fl.rx_done)
    rx_word(0, 16'hFFFF, 16'h0003, "rx count");
    rx_word(1, 16'hFFFF, {b1, b0}, "rx word1");
    rx_word(2, 16'h00FF, 16'h005A, "rx word2");
    send_rx('{pb(), FSPB_CR}, -1);
    rx_word(0, 16'hFFFF, 16'h0003, "count after done");
    restart(1'b0, FSPB_TERM_CR);
    `CHK("rx done cleared", 1'b0, o_flags.rx_done)
    rx_word(0, 16'hFFFF, 16'h0000, "count cleared");
    rx_word(1, 16'hFFFF, {b1, b0}, "contents kept");
    send_rx('{8'h61, FSPB_CR}, -1);
    rx_word(1, 16'h00FF, 16'h0061, "pointer back");
    i_run = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    i_run = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    `CHK("rx done after run", 1'b0, o_flags.rx_done)
    restart(1'b1, FSPB_TERM_ETX);
    send_rx('{pb(), FSPB_STX, pb(), FSPB_STX, b0, b1, FSPB_ETX}, -1);
    rx_word(0, 16'hFFFF, 16'h0002, "count after start");
    rx_word(1, 16'hFFFF, {b1, b0}, "data after start");
    restart(1'b0, FSPB_TERM_CR);
    send_rx('{pb(), pb(), FSPB_CR}, 0);
    `CHK("error set", 1'b1, o_flags.error)
    `CHK("rx after error", 1'b1, o_flags.rx_done)
    restart(1'b0, FSPB_TERM_CR);
    `CHK("error cleared", 1'b0, o_flags.error)
    restart(1'b0, FSPB_TERM_CRLF);
    send_rx('{b0, FSPB_CR, FSPB_LF}, -1);
    `CHK("crlf done", 1'b1, o_flags.rx_done)
    rx_word(0, 16'hFFFF, 16'h0001, "crlf count");
    $display("test receive done");
    give_verdict();
  end
endmodule : test_framed_serial_port_buffer
`default_nettype wire
